// file: src/atrim_regs.sv
// What this block does
// - Offset trim core 3 input C register
// - Offset trim core 3 input D register
// - Offset trim core 4, resets zero
// - Offset trim core 5, resets zero
// - Gain trim core 0, bits 7:5 reserved
// - Gain trim core 1 register
// - Gain trim core 2 input A register
// - Gain trim core 2 input B register
// - Factory defaults load from fuse storage
// - Offset trim fields are unsigned
//
// The AXI4-Lite slave port was chosen for this implementation.
module atrim_regs #(
   parameter int ADDR_W = atrim_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Fuse storage
   input wire logic fuse_valid,
   input wire logic [11:0] fuse_ofs_core3_c,
   input wire logic [11:0] fuse_ofs_core3_d,
   input wire logic [11:0] fuse_ofs_core4,
   input wire logic [11:0] fuse_ofs_core5,
   input wire logic [4:0] fuse_gain_core0,
   input wire logic [4:0] fuse_gain_core1,
   input wire logic [4:0] fuse_gain_core2_a,
   input wire logic [4:0] fuse_gain_core2_b,
   // Trim values to converter cores
   output logic [11:0] trim_ofs_core3_c,
   output logic [11:0] trim_ofs_core3_d,
   output logic [11:0] trim_ofs_core4,
   output logic [11:0] trim_ofs_core5,
   output logic [4:0] trim_gain_core0,
   output logic [4:0] trim_gain_core1,
   output logic [4:0] trim_gain_core2_a,
   output logic [4:0] trim_gain_core2_b
);

   typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} atrim_wr_e;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} atrim_rd_e;

   function automatic logic [3:0] reg_hit(input logic [ADDR_W-1:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      case (idx)
         atrim_pkg::IDX_OFS_CORE3_C: reg_hit = atrim_pkg::HIT_OFS_CORE3_C;
         atrim_pkg::IDX_OFS_CORE3_D: reg_hit = atrim_pkg::HIT_OFS_CORE3_D;
         atrim_pkg::IDX_OFS_CORE4: reg_hit = atrim_pkg::HIT_OFS_CORE4;
         atrim_pkg::IDX_OFS_CORE5: reg_hit = atrim_pkg::HIT_OFS_CORE5;
         atrim_pkg::IDX_GAIN_CORE0: reg_hit = atrim_pkg::HIT_GAIN_CORE0;
         atrim_pkg::IDX_GAIN_CORE1: reg_hit = atrim_pkg::HIT_GAIN_CORE1;
         atrim_pkg::IDX_GAIN_CORE2_A: reg_hit = atrim_pkg::HIT_GAIN_CORE2_A;
         atrim_pkg::IDX_GAIN_CORE2_B: reg_hit = atrim_pkg::HIT_GAIN_CORE2_B;
         atrim_pkg::IDX_CTRL: reg_hit = atrim_pkg::HIT_CTRL;
         atrim_pkg::IDX_STAT: reg_hit = atrim_pkg::HIT_STAT;
         default: reg_hit = atrim_pkg::HIT_NONE;
      endcase
   endfunction

   atrim_wr_e wr_state_q, wr_state_d;
   atrim_rd_e rd_state_q, rd_state_d;
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d, rdata_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic [1:0] bresp_d, rresp_d;
   logic [ADDR_W-1:0] aw_addr_eff;
   logic [31:0] w_data_eff;
   logic [3:0] w_strb_eff, wr_hit, rd_hit;
   logic aw_hs, w_hs, ar_hs, do_write, reload_wr;
   logic load_pend_q, load_pend_d, fuse_load;
   logic [15:0] vals [atrim_pkg::NREG];
   logic [15:0] fuse_val [atrim_pkg::NREG];

   assign awready = (wr_state_q == WR_IDLE) && !aw_hold_q;
   assign wready = (wr_state_q == WR_IDLE) && !w_hold_q;
   assign bvalid = (wr_state_q == WR_RESP);
   assign arready = (rd_state_q == RD_IDLE);
   assign rvalid = (rd_state_q == RD_DATA);
   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign ar_hs = arvalid && arready;
   assign aw_addr_eff = aw_hold_q ? aw_addr_q : awaddr;
   assign w_data_eff = w_hold_q ? w_data_q : wdata;
   assign w_strb_eff = w_hold_q ? w_strb_q : wstrb;
   assign do_write = (wr_state_q == WR_IDLE) && (aw_hold_q || aw_hs)
                     && (w_hold_q || w_hs);
   assign wr_hit = reg_hit(aw_addr_eff);
   assign rd_hit = reg_hit(araddr);
   assign reload_wr = do_write && (wr_hit == atrim_pkg::HIT_CTRL)
                      && w_strb_eff[0]
                      && w_data_eff[atrim_pkg::CTRL_RELOAD_BIT];

   // Write channel: address and data are taken in either order
   always_comb
   begin
      wr_state_d = wr_state_q;
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bresp_d = bresp;
      case (wr_state_q)
         WR_IDLE:
         begin
            if (aw_hs)
            begin
               aw_hold_d = 1'b1;
               aw_addr_d = awaddr;
            end
            if (w_hs)
            begin
               w_hold_d = 1'b1;
               w_data_d = wdata;
               w_strb_d = wstrb;
            end
            if (do_write)
            begin
               aw_hold_d = 1'b0;
               w_hold_d = 1'b0;
               wr_state_d = WR_RESP;
               bresp_d = (wr_hit == atrim_pkg::HIT_NONE) ?
                         atrim_pkg::RESP_SLVERR : atrim_pkg::RESP_OKAY;
            end
         end
         WR_RESP:
         begin
            if (bready)
            begin
               wr_state_d = WR_IDLE;
            end
         end
         default: wr_state_d = WR_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_q <= WR_IDLE;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         bresp <= atrim_pkg::RESP_OKAY;
      end
      else
      begin
         wr_state_q <= wr_state_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp <= bresp_d;
      end
   end

   // Fuse copy pends from reset and on reload; a reload request in the
   // same cycle as the copy wins so the second copy still happens
   assign fuse_load = load_pend_q && fuse_valid;
   always_comb
   begin
      load_pend_d = load_pend_q;
      if (fuse_load)
      begin
         load_pend_d = 1'b0;
      end
      if (reload_wr)
      begin
         load_pend_d = 1'b1;
      end
   end

   assign fuse_val[0] = {4'h0, fuse_ofs_core3_c};
   assign fuse_val[1] = {4'h0, fuse_ofs_core3_d};
   assign fuse_val[2] = {4'h0, fuse_ofs_core4};
   assign fuse_val[3] = {4'h0, fuse_ofs_core5};
   assign fuse_val[4] = {11'h0, fuse_gain_core0};
   assign fuse_val[5] = {11'h0, fuse_gain_core1};
   assign fuse_val[6] = {11'h0, fuse_gain_core2_a};
   assign fuse_val[7] = {11'h0, fuse_gain_core2_b};

   // Reserved bits are stored as written so read-modify-write holds them
   for (genvar g = 0; g < atrim_pkg::NREG; g++)
   begin : g_trim
      localparam int W = (g < 4) ? atrim_pkg::OFS_REG_W :
                                   atrim_pkg::GAIN_REG_W;
      logic [W-1:0] cell_val;
      atrim_cell #(.WIDTH(W), .BYTES(W / 8)) u_cell (
         .aclk(aclk),
         .aresetn(aresetn),
         .wr_en(do_write && (wr_hit == 4'(g))),
         .wr_strb(w_strb_eff[W/8-1:0]),
         .wr_data(w_data_eff[W-1:0]),
         .load_en(fuse_load),
         .load_data(fuse_val[g][W-1:0]),
         .value_q(cell_val)
      );
      assign vals[g] = 16'(cell_val);
   end

   // Only the field bits reach the cores, as unsigned codes
   assign trim_ofs_core3_c = vals[0][11:0];
   assign trim_ofs_core3_d = vals[1][11:0];
   assign trim_ofs_core4 = vals[2][11:0];
   assign trim_ofs_core5 = vals[3][11:0];
   assign trim_gain_core0 = vals[4][4:0];
   assign trim_gain_core1 = vals[5][4:0];
   assign trim_gain_core2_a = vals[6][4:0];
   assign trim_gain_core2_b = vals[7][4:0];

   // Read channel: one read in flight, data registered
   always_comb
   begin
      rd_state_d = rd_state_q;
      rdata_d = rdata;
      rresp_d = rresp;
      case (rd_state_q)
         RD_IDLE:
         begin
            if (ar_hs)
            begin
               rd_state_d = RD_DATA;
               rresp_d = atrim_pkg::RESP_OKAY;
               rdata_d = 32'h0;
               if (rd_hit < 4'(atrim_pkg::NREG))
               begin
                  rdata_d = {16'h0, vals[rd_hit[2:0]]};
               end
               else if (rd_hit == atrim_pkg::HIT_STAT)
               begin
                  rdata_d[atrim_pkg::STAT_BUSY_BIT] = load_pend_q;
               end
               else if (rd_hit == atrim_pkg::HIT_NONE)
               begin
                  rresp_d = atrim_pkg::RESP_SLVERR;
               end
            end
         end
         RD_DATA:
         begin
            if (rready)
            begin
               rd_state_d = RD_IDLE;
            end
         end
         default: rd_state_d = RD_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_q <= RD_IDLE;
         rdata <= 32'h0;
         rresp <= atrim_pkg::RESP_OKAY;
         load_pend_q <= 1'b1;
      end
      else
      begin
         rd_state_q <= rd_state_d;
         rdata <= rdata_d;
         rresp <= rresp_d;
         load_pend_q <= load_pend_d;
      end
   end

   sequence wr_to(logic [3:0] h);
      do_write && (wr_hit == h) && w_strb_eff[0] && !fuse_load;
   endsequence

   sequence rd_of(logic [3:0] h);
      ar_hs && (rd_hit == h);
   endsequence

   offset_trim_core3_input_c_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_to(atrim_pkg::HIT_OFS_CORE3_C) && w_strb_eff[1]
      |=> trim_ofs_core3_c == $past(w_data_eff[11:0]))
      else $error("offset trim 3C did not take the write");

   offset_trim_core3_input_d_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_to(atrim_pkg::HIT_OFS_CORE3_D) && !w_strb_eff[1]
      |=> trim_ofs_core3_d[7:0] == $past(w_data_eff[7:0])
          && trim_ofs_core3_d[11:8] == $past(trim_ofs_core3_d[11:8]))
      else $error("offset trim 3D byte lanes wrong");

   offset_trim_core4_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> trim_ofs_core4 == 12'h0)
      else $error("offset trim 4 not zero after reset");

   offset_trim_core5_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> trim_ofs_core5 == 12'h0 && load_pend_q)
      else $error("offset trim 5 not zero after reset");

   gain_trim_core0_resv_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(atrim_pkg::HIT_GAIN_CORE0)
      |=> rvalid && rdata[31:8] == 24'h0
          && rdata[4:0] == $past(trim_gain_core0))
      else $error("gain trim 0 read wrong");

   gain_trim_core1_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_to(atrim_pkg::HIT_GAIN_CORE1)
      |=> trim_gain_core1 == $past(w_data_eff[4:0]))
      else $error("gain trim 1 did not take the write");

   gain_trim_core2_input_a_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_to(atrim_pkg::HIT_GAIN_CORE2_A)
      |=> bvalid && bresp == atrim_pkg::RESP_OKAY
          && trim_gain_core2_a == $past(w_data_eff[4:0]))
      else $error("gain trim 2A write failed");

   gain_trim_core2_input_b_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_to(atrim_pkg::HIT_GAIN_CORE2_B) ##1 rd_of(atrim_pkg::HIT_GAIN_CORE2_B)
      |=> rdata[4:0] == $past(w_data_eff[4:0], 2))
      else $error("gain trim 2B read back wrong");

   fuse_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fuse_load && !do_write
      |=> trim_ofs_core4 == $past(fuse_ofs_core4)
          && trim_gain_core0 == $past(fuse_gain_core0) && !load_pend_q)
      else $error("fuse defaults not copied");

   ofs_unsigned_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_of(atrim_pkg::HIT_OFS_CORE4)
      |=> rdata[11:0] == $past(trim_ofs_core4))
      else $error("offset trim 4 read differs from core value");

endmodule // atrim_regs

// file: src/atrim_pkg.sv
package atrim_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NREG = 8;

   // Register indices as printed; byte address is four times the index
   localparam logic [9:0] IDX_OFS_CORE3_C = 10'h338;
   localparam logic [9:0] IDX_OFS_CORE3_D = 10'h33a;
   localparam logic [9:0] IDX_OFS_CORE4 = 10'h33c;
   localparam logic [9:0] IDX_OFS_CORE5 = 10'h33e;
   localparam logic [9:0] IDX_GAIN_CORE0 = 10'h360;
   localparam logic [9:0] IDX_GAIN_CORE1 = 10'h361;
   localparam logic [9:0] IDX_GAIN_CORE2_A = 10'h362;
   localparam logic [9:0] IDX_GAIN_CORE2_B = 10'h363;
   localparam logic [9:0] IDX_CTRL = 10'h3f0;
   localparam logic [9:0] IDX_STAT = 10'h3f1;

   // Decoded register numbers
   localparam logic [3:0] HIT_OFS_CORE3_C = 4'h0;
   localparam logic [3:0] HIT_OFS_CORE3_D = 4'h1;
   localparam logic [3:0] HIT_OFS_CORE4 = 4'h2;
   localparam logic [3:0] HIT_OFS_CORE5 = 4'h3;
   localparam logic [3:0] HIT_GAIN_CORE0 = 4'h4;
   localparam logic [3:0] HIT_GAIN_CORE1 = 4'h5;
   localparam logic [3:0] HIT_GAIN_CORE2_A = 4'h6;
   localparam logic [3:0] HIT_GAIN_CORE2_B = 4'h7;
   localparam logic [3:0] HIT_CTRL = 4'h8;
   localparam logic [3:0] HIT_STAT = 4'h9;
   localparam logic [3:0] HIT_NONE = 4'hf;

   // Field layout
   localparam int OFS_REG_W = 16;
   localparam int GAIN_REG_W = 8;
   localparam int OFS_W = 12;
   localparam int GAIN_W = 5;
   localparam int CTRL_RELOAD_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam logic [15:0] TRIM_RESET = 16'h0000;

   // Responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: src/atrim_cell.sv
module atrim_cell #(
   parameter int WIDTH = 16,
   parameter int BYTES = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Software write
   input wire logic wr_en,
   input wire logic [BYTES-1:0] wr_strb,
   input wire logic [WIDTH-1:0] wr_data,
   // Factory default load
   input wire logic load_en,
   input wire logic [WIDTH-1:0] load_data,
   // Stored value
   output logic [WIDTH-1:0] value_q
);

   logic [WIDTH-1:0] value_d;

   // A bus write overrides the fuse copy byte by byte, so a write racing
   // the load is never lost
   always_comb
   begin
      value_d = value_q;
      if (load_en)
      begin
         value_d = load_data;
      end
      if (wr_en)
      begin
         for (int b = 0; b < BYTES; b++)
         begin
            if (wr_strb[b])
            begin
               value_d[b*8 +: 8] = wr_data[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         value_q <= atrim_pkg::TRIM_RESET[WIDTH-1:0];
      end
      else
      begin
         value_q <= value_d;
      end
   end

endmodule // atrim_cell

// file: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic aclk, aresetn, fuse_valid;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r, rr;
   logic [11:0] fz [8];
   logic [11:0] t_o3c, t_o3d, t_o4, t_o5;
   logic [4:0] t_g0, t_g1, t_g2a, t_g2b;
   int error_cnt, total_checks, cyc, i;

   atrim_regs DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .fuse_valid(fuse_valid),
      .fuse_ofs_core3_c(fz[0]), .fuse_ofs_core3_d(fz[1]),
      .fuse_ofs_core4(fz[2]), .fuse_ofs_core5(fz[3]),
      .fuse_gain_core0(fz[4][4:0]), .fuse_gain_core1(fz[5][4:0]),
      .fuse_gain_core2_a(fz[6][4:0]), .fuse_gain_core2_b(fz[7][4:0]),
      .trim_ofs_core3_c(t_o3c), .trim_ofs_core3_d(t_o3d),
      .trim_ofs_core4(t_o4), .trim_ofs_core5(t_o5),
      .trim_gain_core0(t_g0), .trim_gain_core1(t_g1),
      .trim_gain_core2_a(t_g2a), .trim_gain_core2_b(t_g2b));

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // Byte address is four times the printed register index
   function automatic logic [11:0] adr(input int k);
      case (k)
         0: return {atrim_pkg::IDX_OFS_CORE3_C, 2'h0};
         1: return {atrim_pkg::IDX_OFS_CORE3_D, 2'h0};
         2: return {atrim_pkg::IDX_OFS_CORE4, 2'h0};
         3: return {atrim_pkg::IDX_OFS_CORE5, 2'h0};
         4: return {atrim_pkg::IDX_GAIN_CORE0, 2'h0};
         5: return {atrim_pkg::IDX_GAIN_CORE1, 2'h0};
         6: return {atrim_pkg::IDX_GAIN_CORE2_A, 2'h0};
         default: return {atrim_pkg::IDX_GAIN_CORE2_B, 2'h0};
      endcase
   endfunction

   function automatic logic [31:0] trim(input int k);
      case (k)
         0: return {20'h0, t_o3c};
         1: return {20'h0, t_o3d};
         2: return {20'h0, t_o4};
         3: return {20'h0, t_o5};
         4: return {27'h0, t_g0};
         5: return {27'h0, t_g1};
         6: return {27'h0, t_g2a};
         default: return {27'h0, t_g2b};
      endcase
   endfunction

   function automatic logic [31:0] rmask(input int k);
      return (k < 4) ? 32'h0000ffff : 32'h000000ff;
   endfunction

   function automatic logic [31:0] fmask(input int k);
      return (k < 4) ? 32'h00000fff : 32'h0000001f;
   endfunction

   // Field bits only: reserved bits are written as zero
   function automatic logic [31:0] vpat(input int k);
      return (32'hdeadbeef ^ (32'(k) * 32'h01010101)) & fmask(k);
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t response got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] s, output logic [1:0] resp);
      bit ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      wstrb <= s;
      bready <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1)
         begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic test_end(input string n);
      $display("Test %s done, errors so far %0d", n, error_cnt);
   endtask

   task automatic summarize();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs under two hundred cycles; ceiling leaves ample margin
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         $display("ERROR t=%0t timeout", $time);
         summarize();
      end
   end

   initial
   begin
      {aresetn, fuse_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
      fz = '{12'ha5c, 12'h3b7, 12'hfff, 12'h801, 12'h015, 12'h00a,
             12'h01f, 12'h011};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         rd(adr(i), d, r);
         chk(d, 32'h0, "reset value");
         chk_resp(r, atrim_pkg::RESP_OKAY);
         chk(trim(i), 32'h0, "reset trim");
      end
      rd({atrim_pkg::IDX_STAT, 2'h0}, d, r);
      chk(d, 32'h1, "load pending");
      test_end("reset");

      @(posedge aclk);
      fuse_valid <= 1'b1;
      rd({atrim_pkg::IDX_STAT, 2'h0}, d, r);
      chk(d, 32'h0, "load done");
      for (i = 0; i < 8; i++)
      begin
         rd(adr(i), d, r);
         chk(d, {20'h0, fz[i]} & fmask(i), "fuse read");
         chk(trim(i), {20'h0, fz[i]} & fmask(i), "fuse trim");
      end
      test_end("fuse");

      // Back-to-back writes, then readback of every register; no
      // calibration runs here, so offset trims may be touched at any time
      for (i = 0; i < 8; i++)
      begin
         wr(adr(i), vpat(i), 4'hf, r);
         chk_resp(r, atrim_pkg::RESP_OKAY);
      end
      for (i = 0; i < 8; i++)
      begin
         rd(adr(i), d, r);
         chk(d, vpat(i) & rmask(i), "readback");
         chk(trim(i), vpat(i) & fmask(i), "trim");
      end
      test_end("write");

      wr(adr(2), 32'h00000a00, 4'h2, r);
      wr(adr(5), 32'hffffffff, 4'he, r);
      wr(adr(1), 32'h000000c3, 4'h1, r);
      rd(adr(2), d, r);
      chk(d, (vpat(2) & 32'h00ff) | 32'h0a00, "lane write");
      rd(adr(1), d, r);
      chk(d, (vpat(1) & 32'h0f00) | 32'h00c3, "low lane");
      rd(adr(5), d, r);
      chk(d, vpat(5) & 32'hff, "upper lanes");
      chk(trim(5), vpat(5) & 32'h1f, "upper lanes trim");
      // A read taken the cycle after the write lands sees the new value
      fork
         wr(adr(7), 32'h00000015, 4'h1, r);
         begin
            @(posedge aclk);
            rd(adr(7), d, rr);
         end
      join
      chk(d, 32'h15, "write then read");
      chk_resp(rr, atrim_pkg::RESP_OKAY);
      test_end("strobes");

      // Hole just above the last offset register, and one at the top
      wr(12'hcfc, 32'hffffffff, 4'hf, r);
      chk_resp(r, atrim_pkg::RESP_SLVERR);
      wr(12'hffc, 32'hffffffff, 4'hf, r);
      chk_resp(r, atrim_pkg::RESP_SLVERR);
      rd(12'hcfc, d, r);
      chk(d, 32'h0, "unmapped data");
      chk_resp(r, atrim_pkg::RESP_SLVERR);
      rd(adr(3), d, r);
      chk(d, vpat(3) & 32'hffff, "no side effect");
      test_end("unmapped");

      wr({atrim_pkg::IDX_CTRL, 2'h0}, 32'h1, 4'hf, r);
      chk_resp(r, atrim_pkg::RESP_OKAY);
      rd({atrim_pkg::IDX_CTRL, 2'h0}, d, r);
      chk(d, 32'h0, "control reads zero");
      for (i = 0; i < 8; i++)
      begin
         rd(adr(i), d, r);
         chk(d, {20'h0, fz[i]} & fmask(i), "reload read");
         chk(trim(i), {20'h0, fz[i]} & fmask(i), "reload trim");
      end
      test_end("reload");
      summarize();
   end
endmodule // testbench
